// File: design/dcsl_pkg.sv
// constants, register map and carrier types of the dc drive speed loop
// assumes a 125 MHz aclk and a control tick at six times supply frequency
package dcsl_pkg;

  localparam int unsigned CLK_HZ      = 125_000_000;
  localparam int unsigned SUPPLY_HZ   = 50;
  localparam int unsigned TICK_PER_F  = 6;
  localparam int unsigned TICK_CYCLES = CLK_HZ / (TICK_PER_F * SUPPLY_HZ);

  // register byte offsets
  localparam logic [5:0] CTRL_OFS   = 6'h00;
  localparam logic [5:0] ENC_OFS    = 6'h04;
  localparam logic [5:0] MAXV_OFS   = 6'h08;
  localparam logic [5:0] RDSC_OFS   = 6'h0c;
  localparam logic [5:0] GAIN_OFS   = 6'h10;
  localparam logic [5:0] TUNE_OFS   = 6'h14;
  localparam logic [5:0] HREF_OFS   = 6'h18;
  localparam logic [5:0] BRLIM_OFS  = 6'h1c;
  localparam logic [5:0] OVLIM_OFS  = 6'h20;
  localparam logic [5:0] STAT0_OFS  = 6'h24;
  localparam logic [5:0] STAT1_OFS  = 6'h28;
  localparam logic [5:0] STAT2_OFS  = 6'h2c;
  localparam logic [5:0] STAT3_OFS  = 6'h30;
  localparam int unsigned NUM_RW    = 9;

  // ctrl field positions
  localparam int unsigned DIG_FB_BIT  = 0;
  localparam int unsigned AV_FB_BIT   = 1;
  localparam int unsigned HREF_BIT    = 2;
  localparam int unsigned DROOP_BIT   = 3;
  localparam int unsigned RAMP_BIT    = 4;
  localparam int unsigned BOOST_BIT   = 5;
  localparam int unsigned REDUCE_BIT  = 6;
  localparam int unsigned DIV10_BIT   = 7;
  localparam int unsigned DSRC_LSB    = 8;
  localparam int unsigned QUAD_LSB    = 12;

  // reset values and writable masks of the rw words
  localparam logic [31:0] CTRL_RST  = 32'h0000_f110;
  localparam logic [31:0] CTRL_MSK  = 32'h0000_f3ff;
  localparam logic [31:0] ENC_RST   = 32'h0000_01a3;
  localparam logic [31:0] MAXV_RST  = 32'h0000_0258;
  localparam logic [31:0] RDSC_RST  = 32'h0000_06d6;
  localparam logic [31:0] GAIN_RST  = 32'h8000_2850;
  localparam logic [31:0] TUNE_RST  = 32'h0080_1000;
  localparam logic [31:0] TUNE_MSK  = 32'h01ff_ffff;
  localparam logic [31:0] HREF_RST  = 32'h0000_0000;
  localparam logic [31:0] BRLIM_RST = 32'h03e8_03e8;
  localparam logic [31:0] OVLIM_RST = 32'h0000_03e8;
  localparam logic [31:0] W11_MSK   = 32'h0000_07ff;
  localparam logic [31:0] W16_MSK   = 32'h0000_ffff;
  localparam logic [31:0] BRLIM_MSK = 32'h03ff_03ff;

  // arithmetic constants
  localparam int FULL_SCALE   = 1000;
  localparam int DISP_MAX     = 1999;
  localparam int ENC_MAX      = 1999;
  localparam int AV_OVR_NUM   = 6;
  localparam int AV_OVR_DEN   = 5;
  localparam int IR_SHIFT     = 11;
  localparam int FILT_SHIFT   = 8;
  localparam int OFFSET_MID   = 128;
  localparam int ENC_SHIFT    = 8;
  localparam int P_SHIFT      = 4;
  localparam int I_SHIFT      = 8;
  localparam int D_SHIFT      = 4;
  localparam int BOOST_SHIFT  = 2;
  localparam int REDUCE_SHIFT = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    DCSL_DSRC_ERR = 2'h1,
    DCSL_DSRC_DEM = 2'h2,
    DCSL_DSRC_FB  = 2'h3
  } dcsl_dsrc_t;

  typedef struct packed {
    logic              dig_fb;
    logic              av_fb;
    logic              href_sel;
    logic              droop;
    logic              ramp_sel;
    logic              boost;
    logic              reduce;
    logic              div10;
    logic [1:0]        dsrc;
    logic [3:0]        quad_en;
    logic [10:0]       enc_scale;
    logic [10:0]       max_volts;
    logic [10:0]       readout;
    logic [7:0]        p_gain;
    logic [7:0]        i_gain;
    logic [7:0]        d_gain;
    logic [7:0]        filt;
    logic [7:0]        ir_comp;
    logic [7:0]        zero_thr;
    logic [8:0]        offset_fine;
    logic signed [15:0] hard_ref;
    logic [9:0]        br1_lim;
    logic [9:0]        br2_lim;
    logic [9:0]        ovr_lim;
  } dcsl_cfg_t;

  typedef struct packed {
    logic signed [15:0] enc_count;
    logic signed [15:0] tach;
    logic signed [15:0] arm_volts;
    logic signed [15:0] ramp_out;
    logic               ref_on;
  } dcsl_sense_t;

endpackage

// File: design/dcsl_speed_loop.sv
// speed loop of a dc drive: feedback selection, demand, pid, current limits
// assumes sense inputs come from logic on aclk; registers over axi4-lite
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ns
module dcsl_speed_loop
  import dcsl_pkg::*;
#(
  parameter int unsigned TICK_DIV = TICK_CYCLES
) (
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [5:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [5:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire dcsl_sense_t        sense,
  output logic signed [15:0]      current_demand,
  output logic                    voltage_clamp,
  output logic                    zero_speed,
  output logic                    tick
);

  function automatic logic signed [15:0] sat(input logic signed [39:0] v, input int lim);
    logic signed [39:0] l;
    l = 40'(lim);
    if (v > l) sat = 16'(lim);
    else if (v < -l) sat = 16'(-lim);
    else sat = v[15:0];
  endfunction

  // ---- axi4-lite slave ----
  logic [31:0] rw_reg [NUM_RW];
  logic [5:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        aw_have_reg;
  logic        w_have_reg;
  logic        do_write;
  logic [3:0]  widx;
  logic        wmapped;

  assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
  assign widx     = 4'(awaddr_reg[5:2]);
  assign wmapped  = (awaddr_reg[1:0] == 2'h0) && (widx < 4'(NUM_RW));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_reg   <= 1'b0;
      s_axi_awready <= 1'b1;
      awaddr_reg    <= 6'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_reg   <= 1'b1;
      s_axi_awready <= 1'b0;
      awaddr_reg    <= s_axi_awaddr;
    end else if (do_write) begin
      aw_have_reg   <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_reg   <= 1'b0;
      s_axi_wready <= 1'b1;
      wdata_reg    <= 32'h0000_0000;
      wstrb_reg    <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_reg   <= 1'b1;
      s_axi_wready <= 1'b0;
      wdata_reg    <= s_axi_wdata;
      wstrb_reg    <= s_axi_wstrb;
    end else if (do_write) begin
      w_have_reg   <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wmapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  localparam logic [31:0] RST_TAB [NUM_RW] = '{CTRL_RST, ENC_RST, MAXV_RST, RDSC_RST, GAIN_RST,
                                              TUNE_RST, HREF_RST, BRLIM_RST, OVLIM_RST};
  localparam logic [31:0] MSK_TAB [NUM_RW] = '{CTRL_MSK, W11_MSK, W11_MSK, W11_MSK, 32'hffff_ffff,
                                              TUNE_MSK, W16_MSK, BRLIM_MSK, 32'h0000_03ff};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NUM_RW; i++) rw_reg[i] <= RST_TAB[i];
    end else if (do_write && wmapped) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb_reg[b]) begin
          rw_reg[widx][8*b +: 8] <= wdata_reg[8*b +: 8] & MSK_TAB[widx][8*b +: 8];
        end
      end
    end
  end

  // ---- configuration decode ----
  dcsl_cfg_t cfg;
  always_comb begin
    cfg.dig_fb      = rw_reg[0][DIG_FB_BIT];
    cfg.av_fb       = rw_reg[0][AV_FB_BIT];
    cfg.href_sel    = rw_reg[0][HREF_BIT];
    cfg.droop       = rw_reg[0][DROOP_BIT];
    cfg.ramp_sel    = rw_reg[0][RAMP_BIT];
    cfg.boost       = rw_reg[0][BOOST_BIT];
    cfg.reduce      = rw_reg[0][REDUCE_BIT];
    cfg.div10       = rw_reg[0][DIV10_BIT];
    cfg.dsrc        = rw_reg[0][DSRC_LSB +: 2];
    cfg.quad_en     = rw_reg[0][QUAD_LSB +: 4];
    cfg.enc_scale   = (rw_reg[1][10:0] > 11'(ENC_MAX)) ? 11'(ENC_MAX) : rw_reg[1][10:0];
    cfg.max_volts   = (rw_reg[2][10:0] > 11'(FULL_SCALE)) ? 11'(FULL_SCALE) : rw_reg[2][10:0];
    cfg.readout     = (rw_reg[3][10:0] > 11'(DISP_MAX)) ? 11'(DISP_MAX) : rw_reg[3][10:0];
    cfg.p_gain      = rw_reg[4][7:0];
    cfg.i_gain      = rw_reg[4][15:8];
    cfg.d_gain      = rw_reg[4][23:16];
    cfg.filt        = rw_reg[4][31:24];
    cfg.ir_comp     = rw_reg[5][7:0];
    cfg.zero_thr    = rw_reg[5][15:8];
    cfg.offset_fine = rw_reg[5][24:16];
    cfg.hard_ref    = sat(40'(signed'(rw_reg[6][15:0])), FULL_SCALE);
    cfg.br1_lim     = rw_reg[7][9:0];
    cfg.br2_lim     = rw_reg[7][25:16];
    cfg.ovr_lim     = rw_reg[8][9:0];
  end

  // ---- control tick ----
  logic [31:0] tick_cnt_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_reg <= 32'h0000_0000;
      tick         <= 1'b0;
    end else if (tick_cnt_reg >= 32'(TICK_DIV - 1)) begin
      tick_cnt_reg <= 32'h0000_0000;
      tick         <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
      tick         <= 1'b0;
    end
  end

  // ---- loop state ----
  logic signed [15:0] demand_reg, fb_reg, err_reg, integ_reg, loop_reg, ir_reg, disp_reg, tach_reg;
  logic signed [15:0] dsrc_prev_reg;
  logic signed [15:0] enc_fb, av_clamped, av_scaled, av_fb, fb_next, demand_next;
  logic signed [15:0] raw_err, err_next, integ_next, ir_next, dsrc_val, loop_next, disp_next, cur_next;
  logic signed [39:0] p_term, i_step, d_term;
  logic signed [15:0] av_lim, ovr, lim_pos, lim_neg;
  logic               quad_ok;
  logic signed [15:0] zthr, vmax;

  always_comb begin
    enc_fb     = sat((40'(sense.enc_count) * $signed(40'(cfg.enc_scale))) >>> ENC_SHIFT, FULL_SCALE);
    av_lim     = 16'((32'(cfg.max_volts) * AV_OVR_NUM) / AV_OVR_DEN);
    av_clamped = sat(40'(sense.arm_volts), int'(av_lim));
    av_scaled  = (cfg.max_volts == 11'h000) ? 16'sh0000 :
                 16'((40'(av_clamped) * 40'(FULL_SCALE)) / $signed(40'(cfg.max_volts)));
    // compensation lowers apparent speed, droop raises it
    av_fb      = sat(40'(av_scaled) + (cfg.droop ? 40'(ir_reg) : -40'(ir_reg)), FULL_SCALE);
    if (cfg.dig_fb) fb_next = enc_fb;
    else if (cfg.av_fb) fb_next = av_fb;
    else fb_next = sat(40'(sense.tach), FULL_SCALE);
    demand_next = sat((cfg.ramp_sel ? 40'(sense.ramp_out) : 40'sh0)
                    + ((cfg.href_sel && sense.ref_on) ? 40'(cfg.hard_ref) : 40'sh0)
                    + 40'(cfg.offset_fine) - 40'(OFFSET_MID), FULL_SCALE);
    raw_err    = sat(40'(demand_reg) - 40'(fb_reg), FULL_SCALE);
    err_next   = sat(40'(err_reg) + ((40'(raw_err) - 40'(err_reg)) * $signed(40'(cfg.filt)) >>> FILT_SHIFT),
                     FULL_SCALE);
    i_step     = (40'(err_next) * $signed(40'(cfg.i_gain)))
                 >>> (cfg.reduce ? I_SHIFT + REDUCE_SHIFT : I_SHIFT);
    integ_next = sat(40'(integ_reg) + i_step, FULL_SCALE);
    ir_next    = sat((40'(integ_next) * $signed(40'(cfg.ir_comp))) >>> IR_SHIFT, FULL_SCALE);
    p_term     = (40'(err_next) * $signed(40'(cfg.p_gain))) <<< (cfg.boost ? BOOST_SHIFT : 0);
    p_term     = p_term >>> (cfg.reduce ? P_SHIFT + REDUCE_SHIFT : P_SHIFT);
    case (cfg.dsrc)
      DCSL_DSRC_DEM: dsrc_val = demand_next;
      DCSL_DSRC_FB:  dsrc_val = fb_next;
      default:       dsrc_val = err_next;
    endcase
    d_term     = ((40'(dsrc_val) - 40'(dsrc_prev_reg)) * $signed(40'(cfg.d_gain))) >>> D_SHIFT;
    if (cfg.dsrc != DCSL_DSRC_DEM) d_term = -d_term;
    loop_next  = sat(p_term + 40'(integ_next) + d_term, FULL_SCALE);
    disp_next  = sat((40'(fb_next) * $signed(40'(cfg.readout))) / 40'(FULL_SCALE), DISP_MAX);
    zthr       = $signed(16'(cfg.zero_thr));
    vmax       = $signed(16'(cfg.max_volts));
    ovr        = 16'(cfg.ovr_lim);
    lim_pos    = (16'(cfg.br1_lim) < ovr) ? 16'(cfg.br1_lim) : ovr;
    lim_neg    = (16'(cfg.br2_lim) < ovr) ? 16'(cfg.br2_lim) : ovr;
    if (loop_next > lim_pos) cur_next = lim_pos;
    else if (loop_next < -lim_neg) cur_next = -lim_neg;
    else cur_next = loop_next;
    // quadrant 1..4: fwd motoring, rev braking, rev motoring, fwd braking
    if (cur_next > 16'sh0000) quad_ok = (fb_next >= 16'sh0000) ? cfg.quad_en[0] : cfg.quad_en[1];
    else if (cur_next < 16'sh0000) quad_ok = (fb_next < 16'sh0000) ? cfg.quad_en[2] : cfg.quad_en[3];
    else quad_ok = 1'b1;
    if (!quad_ok) cur_next = 16'sh0000;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      demand_reg    <= 16'sh0000;
      fb_reg        <= 16'sh0000;
      err_reg       <= 16'sh0000;
      integ_reg     <= 16'sh0000;
      ir_reg        <= 16'sh0000;
      loop_reg      <= 16'sh0000;
      disp_reg      <= 16'sh0000;
      tach_reg      <= 16'sh0000;
      dsrc_prev_reg <= 16'sh0000;
    end else if (tick) begin
      demand_reg    <= demand_next;
      fb_reg        <= fb_next;
      err_reg       <= err_next;
      integ_reg     <= integ_next;
      ir_reg        <= ir_next;
      loop_reg      <= loop_next;
      disp_reg      <= disp_next;
      tach_reg      <= sat(40'(sense.tach), FULL_SCALE);
      dsrc_prev_reg <= dsrc_val;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      current_demand <= 16'sh0000;
      zero_speed     <= 1'b1;
      voltage_clamp  <= 1'b0;
    end else if (tick) begin
      current_demand <= cur_next;
      zero_speed     <= (fb_next <= zthr) && (fb_next >= -zthr);
      voltage_clamp  <= !(!cfg.dig_fb && cfg.av_fb) &&
                        ((sense.arm_volts > vmax) || (sense.arm_volts < -vmax));
    end
  end

  // ---- read channel ----
  logic [31:0] rd_word;
  logic        rd_ok;
  always_comb begin
    rd_ok   = (s_axi_araddr[1:0] == 2'h0);
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      STAT0_OFS: rd_word = {fb_reg, demand_reg};
      STAT1_OFS: rd_word = {ir_reg, disp_reg};
      STAT2_OFS: rd_word = {integ_reg, err_reg};
      STAT3_OFS: rd_word = {13'h0000, cfg.div10, voltage_clamp, zero_speed, current_demand};
      default: begin
        if (rd_ok && (s_axi_araddr[5:2] < 4'(NUM_RW))) rd_word = rw_reg[s_axi_araddr[5:2]];
        else if (s_axi_araddr == 6'h34) rd_word = {tach_reg, loop_reg};
        else rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  // ---- checks ----
  cur_in_bridge_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (current_demand <= $signed(16'(cfg.br1_lim))) || $changed(cfg.br1_lim) ||
    ($past(tick) == 1'b0 && $stable(current_demand)))
    else $error("current demand above bridge 1 limit");
  cur_neg_bridge_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tick |=> current_demand >= -$signed(16'($past(cfg.br2_lim))))
    else $error("current demand below bridge 2 limit");
  quad_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && !cfg.quad_en[0] && fb_next >= 16'sh0000 |=> current_demand <= 16'sh0000)
    else $error("disabled quadrant 1 drove positive current");
  fb_range_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fb_reg <= 16'sd1000 && fb_reg >= -16'sd1000 && demand_reg <= 16'sd1000 && demand_reg >= -16'sd1000)
    else $error("speed quantity beyond full scale");
  href_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && !cfg.ramp_sel && !cfg.href_sel && cfg.offset_fine == 9'(OFFSET_MID) |=> demand_reg == 16'sh0000)
    else $error("demand not zero with both sources off");
  tach_pick_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && !cfg.dig_fb && !cfg.av_fb && sense.tach <= 16'sd1000 && sense.tach >= -16'sd1000
    |=> fb_reg == $past(sense.tach))
    else $error("tach feedback not passed through");
  ir_calc_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tick |=> ir_reg == 16'((40'(integ_reg) * $signed(40'($past(cfg.ir_comp)))) >>> IR_SHIFT))
    else $error("ir compensation mismatch");
  clamp_av_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tick && !cfg.dig_fb && cfg.av_fb |=> !voltage_clamp)
    else $error("voltage clamp with armature feedback");
  zero_thr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tick ##1 (zero_speed && !tick) [*2] |-> fb_reg <= 16'sd255 && fb_reg >= -16'sd255)
    else $error("zero speed beyond threshold range");
  tick_gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tick |=> !tick)
    else $error("tick longer than one cycle");

endmodule

// File: testbench/dcsl_motor_model.sv
// sensor stand-in for the speed loop: tach, encoder, armature, ramp
// assumes the bench calls set_sense just after a rising edge of aclk
`timescale 1ns/1ns
module dcsl_motor_model
  import dcsl_pkg::*;
(
  input  wire logic               aclk,
  input  wire logic               tick,
  input  wire logic signed [15:0] current_demand,
  output dcsl_sense_t             sense
);
  dcsl_sense_t pend_reg = '0;
  initial sense = '0;
  // new readings land only after a sampling tick, never mid-period
  always @(posedge aclk) begin
    if (tick === 1'b1) begin
      sense <= pend_reg;
    end
  end
  // tach of 1000 means full speed
  task automatic set_sense(input logic signed [15:0] t, e, v, r, input logic on);
    pend_reg <= '{enc_count: e, tach: t, arm_volts: v, ramp_out: r, ref_on: on};
  endtask
endmodule

// File: testbench/dcsl_speed_loop_tb.sv
// self-checking bench of the speed loop over its axi4-lite registers
// assumes a tick every 8 cycles and the motor model on the sense side
`timescale 1ns/1ns
module dcsl_speed_loop_tb import dcsl_pkg::*; ;
  logic               aclk = 1'b0;
  logic               aresetn = 1'b0;
  logic [5:0]         awaddr = 6'h00, araddr = 6'h00;
  logic [31:0]        wdata = 32'h0;
  logic               awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
  logic               awready, wready, bvalid, arready, rvalid, zero_speed, voltage_clamp, tick;
  logic [1:0]         bresp, rresp;
  logic [31:0]        rdata;
  logic signed [15:0] current_demand;
  dcsl_sense_t        sense;
  int                 err_count = 0, n_compared = 0, cyc = 0;
  localparam logic [5:0] RA[9] = '{CTRL_OFS, ENC_OFS, MAXV_OFS, RDSC_OFS, GAIN_OFS, TUNE_OFS, HREF_OFS,
                                   BRLIM_OFS, OVLIM_OFS};
  localparam logic [31:0] RV[9] = '{CTRL_RST, ENC_RST, MAXV_RST, RDSC_RST, GAIN_RST, TUNE_RST, HREF_RST,
                                    BRLIM_RST, OVLIM_RST};

  always #4 aclk = ~aclk;

  dcsl_speed_loop #(.TICK_DIV(8)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sense(sense),
    .current_demand(current_demand), .voltage_clamp(voltage_clamp), .zero_speed(zero_speed), .tick(tick)
  );

  dcsl_motor_model partner_u (.aclk(aclk), .tick(tick), .current_demand(current_demand), .sense(sense));

  task automatic final_report;
    if (err_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [5:0] a, input logic [1:0] er, output logic [31:0] v);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  task automatic rdm(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] v;
    rd(a, RESP_OKAY, v);
    chk(v & m, e);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge aclk iff tick === 1'b1);
    @(posedge aclk);
  endtask

  // new sensor readings, then let the loop settle on them
  task automatic go(input logic [15:0] t, e, v, r, input logic on);
    partner_u.set_sense(t, e, v, r, on);
    wt(4);
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      final_report;
    end
  end

  initial begin
    logic [31:0] v;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 9; i++) rdm(RA[i], 32'hffff_ffff, RV[i]);
    rd(6'h38, RESP_SLVERR, v);
    chk(v, 32'h0);
    wr(6'h02, 32'h0, RESP_SLVERR);
    wr(STAT0_OFS, 32'h0, RESP_SLVERR);
    rdm(CTRL_OFS, 32'hffff_ffff, CTRL_RST);
    for (int d = 1; d < 4; d++) begin
      wr(CTRL_OFS, 32'h0000_f010 | 32'(d << 8), RESP_OKAY);
      rdm(CTRL_OFS, 32'h0000_0300, 32'(d << 8));
    end
    // tach feedback, readout, zero speed, clamp flag
    wr(CTRL_OFS, 32'h0000_f000, RESP_OKAY);
    go(16'h01f4, 16'h0, 16'h0, 16'h0, 1'b0);
    rdm(STAT0_OFS, 32'hffff_ffff, 32'h01f4_0000);
    rdm(STAT1_OFS, 32'h0000_ffff, 32'h0000_036b);
    chk({31'h0, zero_speed}, 32'h0);
    go(16'h0010, 16'h0, 16'h0, 16'h0, 1'b0);
    chk({31'h0, zero_speed}, 32'h1);
    go(16'h0011, 16'h0, 16'h0, 16'h0, 1'b0);
    chk({31'h0, zero_speed}, 32'h0);
    go(16'h05dc, 16'h0, 16'h0259, 16'h0, 1'b0);
    rdm(STAT0_OFS, 32'hffff_0000, 32'h03e8_0000);
    chk({31'h0, voltage_clamp}, 32'h1);
    go(16'h0, 16'h0, 16'h0258, 16'h0, 1'b0);
    chk({31'h0, voltage_clamp}, 32'h0);
    // encoder and armature feedback
    wr(CTRL_OFS, 32'h0000_f001, RESP_OKAY);
    go(16'h0, 16'h0100, 16'h0, 16'h0, 1'b0);
    rdm(STAT0_OFS, 32'hffff_0000, 32'h01a3_0000);
    wr(CTRL_OFS, 32'h0000_f002, RESP_OKAY);
    go(16'h0, 16'h0, 16'h012c, 16'h0, 1'b0);
    rdm(STAT0_OFS, 32'hffff_0000, 32'h01f4_0000);
    go(16'h0, 16'h0, 16'h02bc, 16'h0, 1'b0);
    chk({31'h0, voltage_clamp}, 32'h0);
    // demand paths and offset
    wr(CTRL_OFS, 32'h0000_f004, RESP_OKAY);
    wr(HREF_OFS, 32'h0000_fed4, RESP_OKAY);
    go(16'h0, 16'h0, 16'h0, 16'h00c8, 1'b1);
    rdm(STAT0_OFS, 32'h0000_ffff, 32'h0000_fed4);
    go(16'h0, 16'h0, 16'h0, 16'h00c8, 1'b0);
    rdm(STAT0_OFS, 32'h0000_ffff, 32'h0);
    wr(CTRL_OFS, 32'h0000_f014, RESP_OKAY);
    wr(HREF_OFS, 32'h0000_012c, RESP_OKAY);
    go(16'h0, 16'h0, 16'h0, 16'h00c8, 1'b1);
    rdm(STAT0_OFS, 32'h0000_ffff, 32'h0000_01f4);
    go(16'h0, 16'h0, 16'h0, 16'h0384, 1'b1);
    rdm(STAT0_OFS, 32'h0000_ffff, 32'h0000_03e8);
    wr(CTRL_OFS, 32'h0000_f010, RESP_OKAY);
    wr(TUNE_OFS, 32'h0100_1000, RESP_OKAY);
    go(16'h0, 16'h0, 16'h0, 16'h00c8, 1'b0);
    rdm(STAT0_OFS, 32'h0000_ffff, 32'h0000_0148);
    wr(TUNE_OFS, 32'h0000_1000, RESP_OKAY);
    wt(4);
    rdm(STAT0_OFS, 32'h0000_ffff, 32'h0000_0048);
    // integral, ir output, current limits and quadrants
    wr(TUNE_OFS, 32'h0080_10ff, RESP_OKAY);
    wr(OVLIM_OFS, 32'h0000_012c, RESP_OKAY);
    go(16'h0064, 16'h0, 16'h0, 16'h0258, 1'b0);
    wt(80);
    rdm(STAT2_OFS, 32'hffff_0000, 32'h03e8_0000);
    rdm(STAT1_OFS, 32'hffff_0000, 32'h007c_0000);
    rdm(6'h34, 32'hffff_ffff, 32'h0064_03e8);
    chk({16'h0, current_demand}, 32'h0000_012c);
    wr(BRLIM_OFS, 32'h03e8_00c8, RESP_OKAY);
    wt(4);
    chk({16'h0, current_demand}, 32'h0000_00c8);
    wr(CTRL_OFS, 32'h0000_e010, RESP_OKAY);
    wt(4);
    chk({16'h0, current_demand}, 32'h0);
    wr(CTRL_OFS, 32'h0000_f090, RESP_OKAY);
    rdm(STAT3_OFS, 32'h0004_0000, 32'h0004_0000);
    // integral gain 0 freezes the integral at 1000, so ir stays 124
    wr(GAIN_OFS, 32'h8000_0050, RESP_OKAY);
    wr(CTRL_OFS, 32'h0000_f01a, RESP_OKAY);
    go(16'h0, 16'h0, 16'h012c, 16'h0258, 1'b0);
    rdm(STAT0_OFS, 32'hffff_0000, 32'h0270_0000);
    wr(CTRL_OFS, 32'h0000_f012, RESP_OKAY);
    wt(4);
    rdm(STAT0_OFS, 32'hffff_0000, 32'h0178_0000);
    final_report;
  end
endmodule
